// ==== hw/dwf_top.sv ====
/*
  Descriptor and control word formatter with an AXI4-Lite register slave.
  Assumes a synchronous AXI4-Lite master on clk_sys and one access of each kind at a time.
*/
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "dwf_consts.svh"

module dwf_top import dwf_pkg::*; (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
    mergeBytes = old;
  endfunction

  // Register decode: is the offset one of ours
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `DWF_REG_NEXT);
  endfunction

  // Reset synchroniser
  logic rstMeta_r;   // First stage, read only by the second
  logic rstSync_r;   // Released reset used everywhere else

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Bus-side holding state
  logic        awHave_r;   // Write address captured
  logic        wHave_r;    // Write data captured
  logic [7:0]  awAddr_r;   // Captured write address
  logic [31:0] wData_r;    // Captured write data
  logic [3:0]  wStrb_r;    // Captured byte enables
  logic        doWrite;    // Both halves present, response free

  // Software-visible registers
  logic [31:0] arg_r [4];  // Operation arguments, indexed
  logic [63:0] in_r;       // Operand word
  logic [63:0] out_r;      // Result word
  logic [63:0] ret_r;      // Return word made on entry
  logic [24:0] curMsw_r;   // Address of the current mark word
  logic [24:0] next_r;     // Next rank descriptor pointer
  logic        nextVld_r;  // Next rank pointer valid
  logic        err_r;      // Last operation refused
  logic        chainRo_r;  // Accumulated read-only along a chain
  logic [3:0]  lastCmd_r;  // Last command code accepted
  logic        cmdReq_r;   // Control written, waiting to run
  dwf_exec_type exec_r;    // Sequencer state

  // Sub-block results
  logic [63:0] copyOut;
  logic        copyErr;
  logic [63:0] widenOut;
  logic        widenErr;
  dwf_cmd_type curCmd;

  assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  assign curCmd  = dwf_cmd_type'(lastCmd_r);

  // Write address and data capture, either order
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      awHave_r      <= 1'b0;
      wHave_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= `DWF_RST_REG;
      wStrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clkEn) begin
      // Address taken, ready dropped until used
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_r <= 1'b0;
      end
      // Data taken likewise
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_r <= 1'b0;
      end
      s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHave_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write response
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DWF_RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_r) ? `DWF_RESP_OKAY : `DWF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Argument and operand registers
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      for (int i = 0; i < 4; i++) begin
        arg_r[i] <= `DWF_RST_REG;
      end
      in_r     <= `DWF_RST_WORD;
      cmdReq_r <= 1'b0;
    end else if (clkEn) begin
      if (doWrite && (awAddr_r >= `DWF_REG_ARG0) && (awAddr_r <= `DWF_REG_ARG3)) begin
        arg_r[awAddr_r[3:2] - 2'h2] <= mergeBytes(arg_r[awAddr_r[3:2] - 2'h2],
                                                 wData_r, wStrb_r);
      end
      if (doWrite && awAddr_r == `DWF_REG_IN_LO) begin
        in_r[31:0] <= mergeBytes(in_r[31:0], wData_r, wStrb_r);
      end
      if (doWrite && awAddr_r == `DWF_REG_IN_HI) begin
        in_r[63:32] <= mergeBytes(in_r[63:32], wData_r, wStrb_r);
      end
      // Control write asks for one operation
      cmdReq_r <= doWrite && (awAddr_r == `DWF_REG_CTRL) && wStrb_r[0];
    end
  end

  // Copy descriptor editing
  dwf_copy_desc uCopy (
    .op      (curCmd),
    .inWord  (in_r),
    .arg0    (arg_r[0]),
    .arg1    (arg_r[1]),
    .arg2    (arg_r[2]),
    .outWord (copyOut),
    .err     (copyErr)
  );

  // Arithmetic widening
  dwf_arith_widen uWiden (
    .aType (dwf_arith_type'(arg_r[0][2:0])),
    .raw   (in_r),
    .value (widenOut),
    .err   (widenErr)
  );

  // Sequencer: latch command, then execute one cycle later
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      exec_r    <= EX_IDLE;
      lastCmd_r <= 4'h0;
    end else if (clkEn) begin
      unique case (exec_r)
        EX_IDLE: begin
          if (cmdReq_r) begin
            exec_r    <= EX_RUN;
            lastCmd_r <= wData_r[3:0];
          end
        end
        EX_RUN: begin
          exec_r <= EX_IDLE;
        end
      endcase
    end
  end

  // Execution of the latched command
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      out_r     <= `DWF_RST_WORD;
      ret_r     <= `DWF_RST_WORD;
      curMsw_r  <= 25'h000_0000;
      next_r    <= 25'h000_0000;
      nextVld_r <= 1'b0;
      err_r     <= 1'b0;
      chainRo_r <= 1'b0;
    end else if (clkEn && exec_r == EX_RUN) begin
      err_r <= 1'b0;
      unique case (curCmd)
        CMD_MKCOPY, CMD_SUBARR, CMD_RESTRICT: begin
          out_r <= copyOut;
          err_r <= copyErr;
        end
        CMD_INDEX: begin
          out_r <= copyOut;
          err_r <= copyErr;
          // multirank: pointer leads to next rank copy
          nextVld_r <= !copyErr && in_r[`DWF_CD_MULTI];
          next_r    <= in_r[`DWF_PTR_HI:0];
        end
        CMD_PEW: begin
          // level, segment pointer, entry offset, byte
          out_r <= {1'b0, WK_PEW, arg_r[0][4:0], arg_r[3][2:0], arg_r[2][15:0],
                    11'h000, arg_r[1][`DWF_PTR_HI:0]};
        end
        CMD_CALL: begin
          // new mark word with level and dynamic link
          // static link to the common scope mark
          // override field carried as software gave it
          out_r <= {1'b0, WK_MSW, arg_r[0][4:0], arg_r[3][3:0], 1'b0, curMsw_r,
                    arg_r[1][`DWF_PTR_HI:0]};
          // return word made on every entry
          ret_r <= {1'b0, WK_REW, arg_r[3][20:16], arg_r[3][10:8], arg_r[2][31:16],
                    11'h000, in_r[`DWF_PTR_HI:0]};
          curMsw_r <= arg_r[2][`DWF_PTR_HI:0];
        end
        CMD_ADW: begin
          out_r <= {1'b0, WK_ADW, 2'h0, arg_r[1][0], 32'h0000_0000, arg_r[0][`DWF_PTR_HI:0]};
        end
        CMD_WIDEN: begin
          // short types enter the stack widened
          out_r <= widenOut;
          err_r <= widenErr;
        end
        CMD_CHAIN: begin
          // most restrictive access along the path
          chainRo_r <= (arg_r[0][0] ? 1'b0 : chainRo_r) | in_r[`DWF_CD_ACCESS];
        end
        default: begin
          err_r <= 1'b1;
        end
      endcase
    end
  end

  // Read channel
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `DWF_RST_REG;
      s_axi_rresp   <= `DWF_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= isMapped(s_axi_araddr) ? `DWF_RESP_OKAY : `DWF_RESP_SLVERR;
        unique case (s_axi_araddr)
          `DWF_REG_CTRL:   s_axi_rdata <= {28'h000_0000, lastCmd_r};
          `DWF_REG_STATUS: s_axi_rdata <= {28'h000_0000, chainRo_r, nextVld_r,
                                           err_r, exec_r == EX_RUN || cmdReq_r};
          `DWF_REG_ARG0:   s_axi_rdata <= arg_r[0];
          `DWF_REG_ARG1:   s_axi_rdata <= arg_r[1];
          `DWF_REG_ARG2:   s_axi_rdata <= arg_r[2];
          `DWF_REG_ARG3:   s_axi_rdata <= arg_r[3];
          `DWF_REG_IN_LO:  s_axi_rdata <= in_r[31:0];
          `DWF_REG_IN_HI:  s_axi_rdata <= in_r[63:32];
          `DWF_REG_OUT_LO: s_axi_rdata <= out_r[31:0];
          `DWF_REG_OUT_HI: s_axi_rdata <= out_r[63:32];
          `DWF_REG_CURMSW: s_axi_rdata <= {7'h00, curMsw_r};
          `DWF_REG_RET_LO: s_axi_rdata <= ret_r[31:0];
          `DWF_REG_RET_HI: s_axi_rdata <= ret_r[63:32];
          `DWF_REG_NEXT:   s_axi_rdata <= {7'h00, next_r};
          default:         s_axi_rdata <= `DWF_RST_REG;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks beside the logic
  AST_INDEX_CLEARS: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_INDEX && !copyErr) |=>
    out_r[`DWF_CD_INDEXED] && out_r[`DWF_CD_LIM_HI:`DWF_CD_LIM_LO] == 12'h000 &&
    out_r[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO] == 8'h00)
    else $error("Indexed copy kept limit or spacing");
  AST_COPY_ONLY: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_INDEX && in_r[`DWF_VALUE_TAG]) |=> err_r)
    else $error("Non-copy word altered without error");
  AST_DLINK: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_CALL) |=>
    out_r[`DWF_DLINK_HI:`DWF_DLINK_LO] == $past(curMsw_r))
    else $error("Dynamic link is not the previous mark");
  AST_RET_ON_CALL: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_CALL) |=>
    ret_r[`DWF_KIND_HI:`DWF_KIND_LO] == WK_REW && ret_r[24:0] == $past(in_r[24:0]))
    else $error("Return word not built on entry");
  AST_VALUE_TAG: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_WIDEN) |=> out_r[`DWF_VALUE_TAG])
    else $error("Widened value lacks value tag");
  AST_INT_ZERO_EXP: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_WIDEN && arg_r[0][2:0] == 3'h2) |=>
    out_r[`DWF_ESIGN:`DWF_EMAG_LO] == 11'h000 && out_r[14:0] == $past(in_r[14:0]))
    else $error("Integer widening not lossless");
  AST_CHAIN_STICKY: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (chainRo_r && !(clkEn && exec_r == EX_RUN && curCmd == CMD_CHAIN && arg_r[0][0]))
    |=> chainRo_r)
    else $error("Read-only lost along chain");
  AST_ADW_ACCESS: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_ADW) |=>
    out_r[`DWF_CD_ACCESS] == $past(arg_r[1][0]) && out_r[24:0] == $past(arg_r[0][24:0]))
    else $error("Address word fields wrong");
  AST_MKCOPY_DELTA: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (clkEn && exec_r == EX_RUN && curCmd == CMD_MKCOPY && arg_r[2][7:0] == 8'h00) |=>
    out_r[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO] == `DWF_DELTA_ONE)
    else $error("Single rank spacing is not one");
  AST_BRESP_WAIT: assert property (@(posedge clk_sys) disable iff (!rstSync_r)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("Write response dropped early");

endmodule

// ==== hw/dwf_consts.svh ====
/*
  Offsets, field positions and reset values of the word formatter.
  Assumes it is included by bare name into each design module file.
*/
`ifndef DWF_CONSTS_SVH
`define DWF_CONSTS_SVH

// Register byte offsets on the 32-bit bus
`define DWF_REG_CTRL    8'h00
`define DWF_REG_STATUS  8'h04
`define DWF_REG_ARG0    8'h08
`define DWF_REG_ARG1    8'h0C
`define DWF_REG_ARG2    8'h10
`define DWF_REG_ARG3    8'h14
`define DWF_REG_IN_LO   8'h18
`define DWF_REG_IN_HI   8'h1C
`define DWF_REG_OUT_LO  8'h20
`define DWF_REG_OUT_HI  8'h24
`define DWF_REG_CURMSW  8'h28
`define DWF_REG_RET_LO  8'h2C
`define DWF_REG_RET_HI  8'h30
`define DWF_REG_NEXT    8'h34

// Bus responses
`define DWF_RESP_OKAY   2'h0
`define DWF_RESP_SLVERR 2'h2

// Common word fields
`define DWF_VALUE_TAG   63
`define DWF_KIND_HI     62
`define DWF_KIND_LO     60
`define DWF_PTR_HI      24
`define DWF_PTR_W       25

// Copy descriptor fields
`define DWF_CD_MULTI    59
`define DWF_CD_INDEXED  58
`define DWF_CD_ACCESS   57
`define DWF_CD_LIM_HI   56
`define DWF_CD_LIM_LO   45
`define DWF_CD_OFS_HI   44
`define DWF_CD_OFS_LO   33
`define DWF_CD_DLT_HI   32
`define DWF_CD_DLT_LO   25
`define DWF_LIMIT_W     12
`define DWF_DELTA_W     8
`define DWF_DELTA_ONE   8'h01

// Control word fields
`define DWF_LL_HI       59
`define DWF_LL_LO       55
`define DWF_LL_W        5
`define DWF_BYTE_HI     54
`define DWF_BYTE_LO     52
`define DWF_ENTRY_HI    51
`define DWF_ENTRY_LO    36
`define DWF_INTERRUPT_OVERRIDE_FIELD_HI     54
`define DWF_INTERRUPT_OVERRIDE_FIELD_LO     51
`define DWF_DLINK_HI    49
`define DWF_DLINK_LO    25

// Stack value layout
`define DWF_MSIGN       62
`define DWF_ESIGN       61
`define DWF_EMAG_HI     60
`define DWF_EMAG_LO     51
`define DWF_MANT_W      51

// Reset values
`define DWF_RST_WORD    64'h0000_0000_0000_0000
`define DWF_RST_REG     32'h0000_0000

`endif

// ==== hw/dwf_pkg.sv ====
/*
  Types shared by the word formatter modules.
  Assumes the constants header is available alongside.
*/
package dwf_pkg;

  // Operations started by a control write
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MKCOPY, CMD_INDEX, CMD_SUBARR, CMD_RESTRICT,
    CMD_PEW, CMD_CALL, CMD_ADW, CMD_WIDEN, CMD_CHAIN
  } dwf_cmd_type;

  // Memory-side element types
  typedef enum logic [2:0] {
    AT_AR63, AT_AR32, AT_AR16, AT_AR8, AT_CHAR
  } dwf_arith_type;

  // Kinds of tagged non-value words
  typedef enum logic [2:0] {
    WK_COPY, WK_PEW, WK_REW, WK_MSW, WK_ADW
  } dwf_kind_type;

  // Command sequencer
  typedef enum logic [1:0] {
    EX_IDLE, EX_RUN
  } dwf_exec_type;

endpackage

// ==== hw/dwf_copy_desc.sv ====
/*
  Combinational builder and editor of copy descriptors.
  Assumes the caller registers the result and the error flag.
*/
`timescale 1ns/1ps
`include "dwf_consts.svh"

module dwf_copy_desc import dwf_pkg::*; (
  // Operation select
  input  wire dwf_cmd_type op,
  // Operands
  input  wire logic [63:0] inWord,
  input  wire logic [31:0] arg0,
  input  wire logic [31:0] arg1,
  input  wire logic [31:0] arg2,
  // Result
  output logic      [63:0] outWord,
  output logic             err
);

  // Element position: base plus steps of the spacing, kept to the field width
  function automatic logic [11:0] elemPos(input logic [11:0] base,
                                          input logic [11:0] idx,
                                          input logic [7:0]  dlt);
    logic [19:0] prod;
    prod    = idx * dlt;
    elemPos = base + prod[11:0];
  endfunction

  // Fields of the incoming word
  logic        isCopy;
  logic [11:0] inOfs;
  logic [11:0] inLim;
  logic [7:0]  inDlt;

  always_comb begin
    isCopy = !inWord[`DWF_VALUE_TAG] &&
             (inWord[`DWF_KIND_HI:`DWF_KIND_LO] == WK_COPY);
    inOfs  = inWord[`DWF_CD_OFS_HI:`DWF_CD_OFS_LO];
    inLim  = inWord[`DWF_CD_LIM_HI:`DWF_CD_LIM_LO];
    inDlt  = inWord[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO];
  end

  // Operation decode
  always_comb begin
    outWord = inWord;
    err     = 1'b0;
    unique case (op)
      CMD_MKCOPY: begin
        outWord = `DWF_RST_WORD;
        outWord[`DWF_KIND_HI:`DWF_KIND_LO] = WK_COPY;
        outWord[`DWF_PTR_HI:0] = arg0[`DWF_PTR_HI:0];
        outWord[`DWF_CD_LIM_HI:`DWF_CD_LIM_LO] = arg1[11:0];
        outWord[`DWF_CD_OFS_HI:`DWF_CD_OFS_LO] = 12'h000;
        outWord[`DWF_CD_ACCESS] = arg1[12];
        outWord[`DWF_CD_MULTI]  = arg1[13];
        // spacing, single rank defaults to one
        outWord[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO] =
          (arg2[7:0] == 8'h00) ? `DWF_DELTA_ONE : arg2[7:0];
      end
      CMD_INDEX: begin
        // only an unindexed copy may change
        err = !isCopy || inWord[`DWF_CD_INDEXED] || (arg0[11:0] > inLim);
        // single element: offset set, limit and spacing cleared
        outWord[`DWF_CD_INDEXED] = 1'b1;
        outWord[`DWF_CD_OFS_HI:`DWF_CD_OFS_LO] = elemPos(inOfs, arg0[11:0], inDlt);
        outWord[`DWF_CD_LIM_HI:`DWF_CD_LIM_LO] = 12'h000;
        outWord[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO] = 8'h00;
      end
      CMD_SUBARR: begin
        // partition acts on a copy only
        err = !isCopy || inWord[`DWF_CD_INDEXED];
        // sub-array start within the whole array
        outWord[`DWF_CD_OFS_HI:`DWF_CD_OFS_LO] = elemPos(inOfs, arg0[11:0], inDlt);
        outWord[`DWF_CD_LIM_HI:`DWF_CD_LIM_LO] = arg1[11:0];
        outWord[`DWF_CD_DLT_HI:`DWF_CD_DLT_LO] = arg2[7:0];
      end
      CMD_RESTRICT: begin
        err = !isCopy;
        outWord[`DWF_CD_ACCESS] = 1'b1;
      end
      default: begin
        err = 1'b1;
      end
    endcase
  end

endmodule

// ==== hw/dwf_arith_widen.sv ====
/*
  Combinational widening of memory arithmetic types to the stack value form.
  Assumes the caller registers the result and the error flag.
*/
`timescale 1ns/1ps
`include "dwf_consts.svh"

module dwf_arith_widen import dwf_pkg::*; (
  // Element type and raw bits
  input  wire dwf_arith_type aType,
  input  wire logic [63:0]   raw,
  // Stack value
  output logic      [63:0]   value,
  output logic               err
);

  // Sign-magnitude placement with the point right of bit 0
  always_comb begin
    value = `DWF_RST_WORD;
    err   = 1'b0;
    unique case (aType)
      AT_AR63: begin
        // already in stack form, tag forced
        value = raw;
      end
      AT_AR32: begin
        // eight-bit exponent, 23-bit mantissa kept whole
        value[`DWF_MSIGN] = raw[31];
        value[`DWF_ESIGN] = raw[30];
        value[`DWF_EMAG_HI:`DWF_EMAG_LO] = {3'h0, raw[29:23]};
        value[22:0] = raw[22:0];
      end
      AT_AR16: begin
        value[`DWF_MSIGN] = raw[15];
        value[14:0] = raw[14:0];
      end
      AT_AR8: begin
        value[`DWF_MSIGN] = raw[7];
        value[6:0] = raw[6:0];
      end
      default: begin
        err = 1'b1;
      end
    endcase
    // value tag marks a value, not a name
    value[`DWF_VALUE_TAG] = 1'b1;
  end

endmodule

// ==== testbench/dwf_axi_master.sv ====
/* AXI4-Lite master model standing in for the processor side.
   Assumes the bench calls one task at a time, after reset. */
`timescale 1ns/1ps
module dwf_axi_master (
  // Clock
  input  wire logic        clk_sys,
  // Write address and data
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  // Write response
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Write: both channels offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    fork
      begin
        do @(posedge clk_sys); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      begin
        do @(posedge clk_sys); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    join
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read: address until taken, data when valid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== testbench/dwf_top_tb.sv ====
/* Bench for the word formatter: builds words through registers.
   Assumes the master model and the design sources are compiled. */
`timescale 1ns/1ps
`include "dwf_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dwf_top_tb import dwf_pkg::*; ;
  logic        clk_sys = 1'b0;  // System clock
  logic        rst_b   = 1'b0;  // Reset, active low
  int          mismatches = 0;  // Failed compares
  int          checks     = 0;  // All compares
  int          cycles     = 0;  // Watchdog count
  logic [1:0]  rsp;             // Last response
  logic [31:0] dat;             // Last read data
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  always #50 clk_sys = ~clk_sys;
  dwf_top uut (.clk_sys, .rst_b, .clkEn(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dwf_axi_master m (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Verdict and end of run
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  // Read one word and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    m.rd(a, dat, rsp);
    `CHK(dat, e)
  endtask
  // Read a word pair and compare
  task automatic r64(input logic [7:0] a, input logic [63:0] e);
    rchk(a, e[31:0]);
    rchk(a + 8'h04, e[63:32]);
  endtask
  // Load the input word
  task automatic put(input logic [63:0] w);
    m.wr(`DWF_REG_IN_LO, w[31:0], rsp);
    m.wr(`DWF_REG_IN_HI, w[63:32], rsp);
  endtask
  // Arguments, command, then the fixed result latency
  task automatic run(input dwf_cmd_type c, input logic [31:0] a [4]);
    for (int i = 0; i < 4; i++) m.wr(8'h08 + 8'(4 * i), a[i], rsp);
    m.wr(`DWF_REG_CTRL, {28'h0, c}, rsp);
    repeat (4) @(posedge clk_sys);
  endtask
  // Unmapped place and cleared output
  task automatic t_bus;
    rchk(`DWF_REG_OUT_LO, 32'h0);
    m.rd(8'h3C, dat, rsp);
    `CHK(rsp, `DWF_RESP_SLVERR)
  endtask
  // Fresh copy: full limit, spacing zero taken as one
  task automatic t_copy;
    run(CMD_MKCOPY, '{32'h01AB_CDEF, 32'h3FFF, 32'h0, 32'h0});
    r64(`DWF_REG_OUT_LO, {4'h0, 3'b101, 12'hFFF, 12'h0, 8'h01, 25'h1AB_CDEF});
  endtask
  // Index at the limit, then one past it
  task automatic t_index;
    put({4'h0, 3'b100, 12'h008, 12'h002, 8'h03, 25'h5});
    run(CMD_INDEX, '{32'h8, 32'h0, 32'h0, 32'h0});
    r64(`DWF_REG_OUT_LO, {4'h0, 3'b110, 12'h0, 12'h01A, 8'h00, 25'h5});
    rchk(`DWF_REG_NEXT, 32'h5);
    rchk(`DWF_REG_STATUS, 32'h4);
    run(CMD_INDEX, '{32'h9, 32'h0, 32'h0, 32'h0});
    m.rd(`DWF_REG_STATUS, dat, rsp);
    `CHK(dat[1], 1'b1)
  endtask
  // Entry, call pair and address words
  task automatic t_ctrl;
    run(CMD_PEW, '{32'h13, 32'h000A_BCDE, 32'hBEEF, 32'h5});
    r64(`DWF_REG_OUT_LO, {4'h1, 5'h13, 3'h5, 16'hBEEF, 11'h0, 25'h0AB_CDE});
    run(CMD_CALL, '{32'h1, 32'h1, 32'h111, 32'h0});
    run(CMD_CALL, '{32'h7, 32'h222, 32'h1234_0333, 32'h0006_020A});
    r64(`DWF_REG_OUT_LO, {4'h3, 5'h07, 4'hA, 1'b0, 25'h111, 25'h222});
    r64(`DWF_REG_RET_LO, {4'h2, 5'h06, 3'h2, 16'h1234, 11'h0, 25'h5});
    rchk(`DWF_REG_CURMSW, 32'h0034_0333);
    run(CMD_ADW, '{32'h01FF_FFFF, 32'h1, 32'h0, 32'h0});
    r64(`DWF_REG_OUT_LO, {4'h4, 3'b001, 32'h0, 25'h1FF_FFFF});
  endtask
  // Sub-array, read-only copy, refusal of a value word
  task automatic t_sub;
    put({4'h0, 3'b000, 12'h010, 12'h001, 8'h02, 25'h7});
    run(CMD_SUBARR, '{32'h3, 32'h5, 32'hFF, 32'h0});
    r64(`DWF_REG_OUT_LO, {4'h0, 3'b000, 12'h005, 12'h007, 8'hFF, 25'h7});
    run(CMD_RESTRICT, '{32'h0, 32'h0, 32'h0, 32'h0});
    r64(`DWF_REG_OUT_LO, {4'h0, 3'b001, 12'h010, 12'h001, 8'h02, 25'h7});
    put(64'h8000_0000_0000_0000);
    run(CMD_INDEX, '{32'h0, 32'h0, 32'h0, 32'h0});
    rchk(`DWF_REG_STATUS, 32'h2);
  endtask
  // Widening, character refusal, chained access
  task automatic t_data;
    put(64'h8005);
    run(CMD_WIDEN, '{32'h2, 32'h0, 32'h0, 32'h0});
    r64(`DWF_REG_OUT_LO, {2'b11, 11'h0, 51'h5});
    run(CMD_WIDEN, '{32'h4, 32'h0, 32'h0, 32'h0});
    m.rd(`DWF_REG_STATUS, dat, rsp);
    `CHK(dat[1], 1'b1)
    put(64'h0200_0000_0000_0000);
    run(CMD_CHAIN, '{32'h1, 32'h0, 32'h0, 32'h0});
    put(64'h0);
    run(CMD_CHAIN, '{32'h0, 32'h0, 32'h0, 32'h0});
    m.rd(`DWF_REG_STATUS, dat, rsp);
    `CHK(dat[3], 1'b1)
  endtask
  // Reset, then every scenario
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_bus();
    t_copy();
    t_index();
    t_ctrl();
    t_sub();
    t_data();
    complete_run();
  end
endmodule
